// ==== rtl/cob_pkg.sv ====
// constants and types for the operand and branch block
//
// Summary of operation
// - Bit toggle flips only the indexed bit of the operand, copies the result to acc, updates Z.
// - Flag snapshot loads acc[7:4] with C, C xor V, call pile full, call pile empty; flags kept.
// - Register shift-load puts operand<<1 in acc with bit 0 clear, old bit 7 in C, clears V, sets Z from acc.
// - Memory shift-load does the same on the addressed data store byte.
// - Divide operation picks undivided, /2, /4, /8 or /16 for the cpu clock; flags kept.
// - Eight addressing modes over four pointers; pointer update happens in the accessing op.
// - Immediate offset mode addresses pointer plus constant and leaves the pointer alone.
// - Register offset mode addresses pointer plus offset register, pointer unchanged.
// - Post-increment addresses the pointer, then adds one to it.
// - Post-increment by offset addresses pointer plus constant and writes that sum back.
// - Pre-decrement lowers the pointer by one and addresses the lowered value.
// - Pre-decrement by offset subtracts the constant, writes it back and addresses it.
// - Thirteen jump conditions: C, Z, V set or clear, either event line, six compare outcomes.
package cob_pkg;
  // ==================================================
  // register map
  localparam logic [11:0] OFF_OP = 12'h000;
  localparam logic [11:0] OFF_OPND = 12'h004;
  localparam logic [11:0] OFF_PTR0 = 12'h008;
  localparam logic [11:0] OFF_PTR3 = 12'h014;
  localparam logic [11:0] OFF_OFFREG = 12'h018;
  localparam logic [11:0] OFF_FLAGS = 12'h01C;
  localparam logic [11:0] OFF_ACC = 12'h020;
  localparam logic [11:0] OFF_RESULT = 12'h024;
  localparam logic [11:0] OFF_COND = 12'h028;
  localparam logic [11:0] OFF_EADDR = 12'h02C;
  localparam logic [11:0] OFF_DS_BASE = 12'h400;
  localparam int unsigned DS_DEPTH = 256;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==================================================
  // field positions
  localparam int unsigned OP_SEL_LSB = 0;
  localparam int unsigned OP_BIT_LSB = 4;
  localparam int unsigned OP_MODE_LSB = 8;
  localparam int unsigned OP_PSEL_LSB = 12;
  localparam int unsigned OPND_REG_LSB = 0;
  localparam int unsigned OPND_IMM_LSB = 8;
  localparam int unsigned OPND_OP2_LSB = 16;
  localparam int unsigned FLAG_C_BIT = 0;
  localparam int unsigned FLAG_V_BIT = 1;
  localparam int unsigned FLAG_Z_BIT = 2;
  localparam int unsigned FLAG_FULL_BIT = 3;
  localparam int unsigned FLAG_EMPTY_BIT = 4;
  localparam int unsigned FLAG_DIV_LSB = 8;
  // ==================================================
  // reset values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [3:0] SNAP_LOW = 4'h0;
  // ==================================================
  // types
  typedef enum logic [3:0] {
    OP_INVB = 4'h0, OP_SFLAG = 4'h1, OP_RFLAG_REG = 4'h2, OP_RFLAG_MEM = 4'h3,
    OP_FREQ = 4'h4, OP_CMP = 4'h5, OP_LOAD = 4'h6, OP_STORE = 4'h7
  } cob_op_t;
  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_IND = 3'h1, AM_IND_IMM = 3'h2, AM_IND_REG = 3'h3,
    AM_POST_INC = 3'h4, AM_POST_IMM = 3'h5, AM_PRE_DEC = 3'h6, AM_PRE_IMM = 3'h7
  } cob_mode_t;
  typedef enum logic [2:0] {
    DIV_NONE = 3'h0, DIV_2 = 3'h1, DIV_4 = 3'h2, DIV_8 = 3'h3, DIV_16 = 3'h4
  } cob_div_t;
  typedef enum logic [3:0] {
    BRANCH_CARRY_ONE = 4'h0, BRANCH_CARRY_ZERO = 4'h1,
    BRANCH_ZERO_FLAG_ONE = 4'h2, BRANCH_ZERO_FLAG_CLEAR = 4'h3,
    BRANCH_OVERFLOW_ONE = 4'h4, BRANCH_OVERFLOW_CLEAR = 4'h5,
    BRANCH_ON_PENDING_SIGNAL = 4'h6, BRANCH_SAME = 4'h7, BRANCH_DIFFER = 4'h8,
    BRANCH_ABOVE = 4'h9, BRANCH_ABOVE_OR_SAME = 4'hA, BRANCH_BELOW = 4'hB,
    BRANCH_BELOW_OR_SAME = 4'hC
  } cob_cond_t;
endpackage : cob_pkg

// ==== rtl/cob_agu_if.sv ====
// address generation signals between core and address unit
`timescale 1ns/1ps
interface cob_agu_if;
  logic [2:0] mode;
  logic [15:0] ptr;
  logic [7:0] imm;
  logic [7:0] regoff;
  logic [15:0] eaddr;
  logic [15:0] next_ptr;
  logic ptr_upd;
  modport core (output mode, ptr, imm, regoff, input eaddr, next_ptr, ptr_upd);
  modport agu (input mode, ptr, imm, regoff, output eaddr, next_ptr, ptr_upd);
endinterface : cob_agu_if

// ==== rtl/cob_agu.sv ====
// effective address and pointer update for the eight modes
`timescale 1ns/1ps
module cob_agu (
  // address request and answer
  cob_agu_if.agu a
);
  logic [15:0] sum_imm;
  logic [15:0] dif_imm;
  assign sum_imm = a.ptr + {8'h00, a.imm};
  assign dif_imm = a.ptr - {8'h00, a.imm};
  always_comb begin
    a.eaddr = a.ptr;
    a.next_ptr = a.ptr;
    a.ptr_upd = 1'b0;
    case (cob_pkg::cob_mode_t'(a.mode))
      cob_pkg::AM_DIRECT: a.eaddr = {8'h00, a.imm};
      cob_pkg::AM_IND: a.eaddr = a.ptr;
      cob_pkg::AM_IND_IMM: a.eaddr = sum_imm;
      cob_pkg::AM_IND_REG: a.eaddr = a.ptr + {8'h00, a.regoff};
      cob_pkg::AM_POST_INC: begin
        a.eaddr = a.ptr;
        a.next_ptr = a.ptr + 16'h0001;
        a.ptr_upd = 1'b1;
      end
      cob_pkg::AM_POST_IMM: begin
        a.eaddr = sum_imm;
        a.next_ptr = sum_imm;
        a.ptr_upd = 1'b1;
      end
      cob_pkg::AM_PRE_DEC: begin
        a.next_ptr = a.ptr - 16'h0001;
        a.eaddr = a.next_ptr;
        a.ptr_upd = 1'b1;
      end
      cob_pkg::AM_PRE_IMM: begin
        a.eaddr = dif_imm;
        a.next_ptr = dif_imm;
        a.ptr_upd = 1'b1;
      end
      default: a.eaddr = a.ptr;
    endcase
  end
endmodule : cob_agu

// ==== rtl/cob_cond.sv ====
// jump condition evaluation
`timescale 1ns/1ps
module cob_cond (
  // condition select and flags
  input wire logic [3:0] code,
  input wire logic flag_c,
  input wire logic flag_v,
  input wire logic flag_z,
  // event lines
  input wire logic ev0,
  input wire logic ev1,
  // result
  output logic taken
);
  always_comb begin
    case (cob_pkg::cob_cond_t'(code))
      cob_pkg::BRANCH_CARRY_ONE: taken = flag_c;
      cob_pkg::BRANCH_CARRY_ZERO: taken = ~flag_c;
      cob_pkg::BRANCH_ZERO_FLAG_ONE: taken = flag_z;
      cob_pkg::BRANCH_ZERO_FLAG_CLEAR: taken = ~flag_z;
      cob_pkg::BRANCH_OVERFLOW_ONE: taken = flag_v;
      cob_pkg::BRANCH_OVERFLOW_CLEAR: taken = ~flag_v;
      cob_pkg::BRANCH_ON_PENDING_SIGNAL: taken = ev0 | ev1;
      cob_pkg::BRANCH_SAME: taken = flag_z;
      cob_pkg::BRANCH_DIFFER: taken = ~flag_z;
      cob_pkg::BRANCH_ABOVE: taken = flag_c & ~flag_z;
      cob_pkg::BRANCH_ABOVE_OR_SAME: taken = flag_c;
      cob_pkg::BRANCH_BELOW: taken = ~flag_c;
      cob_pkg::BRANCH_BELOW_OR_SAME: taken = ~flag_c | flag_z;
      default: taken = 1'b0;
    endcase
  end
endmodule : cob_cond

// ==== rtl/cob_top.sv ====
// operand, addressing and branch logic with its register slave
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module cob_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // write address
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read address
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // core status
  input wire logic CALL_PILE_FULL,
  input wire logic CALL_PILE_EMPTY,
  input wire logic EVENT_LINE_ZERO,
  input wire logic EVENT_LINE_ONE,
  // outputs
  output logic [2:0] CPU_CLK_DIV,
  output logic JUMP_TAKEN
);
  // ==================================================
  // helpers
  function automatic logic [11:0] word_of(input logic [11:0] ad);
    word_of = {ad[11:2], 2'b00};
  endfunction : word_of

  function automatic logic is_ds(input logic [11:0] ad);
    is_ds = (ad >= cob_pkg::OFF_DS_BASE)
      && ({1'b0, ad} < 13'(cob_pkg::OFF_DS_BASE) + 13'(4 * cob_pkg::DS_DEPTH));
  endfunction : is_ds

  function automatic logic is_reg(input logic [11:0] ad);
    is_reg = (word_of(ad) <= cob_pkg::OFF_EADDR);
  endfunction : is_reg

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // ==================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==================================================
  // state
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [1:0] rresp;
  logic [31:0] rdata;
  cob_pkg::cob_op_t op_sel;
  logic [2:0] bit_sel;
  logic [2:0] mode;
  logic [1:0] ptr_sel;
  logic [7:0] opnd_reg;
  logic [7:0] opnd_imm;
  logic [7:0] opnd_op2;
  logic [15:0] ptr [4];
  logic [7:0] offset_reg;
  logic flag_c;
  logic flag_v;
  logic flag_z;
  logic [7:0] acc;
  logic [7:0] result;
  logic [3:0] cond_code;
  logic jump_taken;
  logic [15:0] eaddr_last;
  cob_pkg::cob_div_t cpu_div;
  logic exec_go;
  logic [7:0] data_store [cob_pkg::DS_DEPTH];

  // ==================================================
  // bus handshake
  logic wr_fire;
  logic [11:0] wr_off;
  logic [31:0] wr_ops;
  logic [31:0] wr_opnd;
  logic [31:0] wr_flags;
  logic [7:0] wr_ds_idx;
  logic [7:0] rd_ds_idx;
  assign wr_fire = aw_held & w_held;
  assign wr_off = word_of(aw_addr);
  assign wr_ds_idx = 8'((aw_addr - cob_pkg::OFF_DS_BASE) >> 2);
  assign rd_ds_idx = 8'((S_AXI_ARADDR - cob_pkg::OFF_DS_BASE) >> 2);
  assign S_AXI_AWREADY = ~aw_held & ~bvalid;
  assign S_AXI_WREADY = ~w_held & ~bvalid;
  assign S_AXI_ARREADY = ~rvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;
  assign CPU_CLK_DIV = cpu_div;
  assign JUMP_TAKEN = jump_taken;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= cob_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (is_reg(aw_addr) || is_ds(aw_addr)) ? cob_pkg::RESP_OKAY : cob_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  // ==================================================
  // read side
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    case (word_of(S_AXI_ARADDR))
      cob_pkg::OFF_OP: begin
        rd_word[cob_pkg::OP_SEL_LSB +: 4] = op_sel;
        rd_word[cob_pkg::OP_BIT_LSB +: 3] = bit_sel;
        rd_word[cob_pkg::OP_MODE_LSB +: 3] = mode;
        rd_word[cob_pkg::OP_PSEL_LSB +: 2] = ptr_sel;
      end
      cob_pkg::OFF_OPND: rd_word[23:0] = {opnd_op2, opnd_imm, opnd_reg};
      cob_pkg::OFF_OFFREG: rd_word[7:0] = offset_reg;
      cob_pkg::OFF_FLAGS: begin
        rd_word[cob_pkg::FLAG_C_BIT] = flag_c;
        rd_word[cob_pkg::FLAG_V_BIT] = flag_v;
        rd_word[cob_pkg::FLAG_Z_BIT] = flag_z;
        rd_word[cob_pkg::FLAG_FULL_BIT] = CALL_PILE_FULL;
        rd_word[cob_pkg::FLAG_EMPTY_BIT] = CALL_PILE_EMPTY;
        rd_word[cob_pkg::FLAG_DIV_LSB +: 3] = cpu_div;
      end
      cob_pkg::OFF_ACC: rd_word[7:0] = acc;
      cob_pkg::OFF_RESULT: rd_word[7:0] = result;
      cob_pkg::OFF_COND: rd_word[4:0] = {jump_taken, cond_code};
      cob_pkg::OFF_EADDR: rd_word[15:0] = eaddr_last;
      default: begin
        if (word_of(S_AXI_ARADDR) >= cob_pkg::OFF_PTR0
            && word_of(S_AXI_ARADDR) <= cob_pkg::OFF_PTR3) begin
          rd_word[15:0] = ptr[2'((S_AXI_ARADDR - cob_pkg::OFF_PTR0) >> 2)];
        end else if (is_ds(S_AXI_ARADDR)) begin
          rd_word[7:0] = data_store[rd_ds_idx];
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rresp <= cob_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (is_reg(S_AXI_ARADDR) || is_ds(S_AXI_ARADDR)) ? cob_pkg::RESP_OKAY
                                                               : cob_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // ==================================================
  // operation register and start pulse
  assign wr_ops = merge({16'h0000, 2'b00, ptr_sel, 1'b0, mode, 1'b0, bit_sel, op_sel},
                        w_data, w_strb);
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      op_sel <= cob_pkg::OP_INVB;
      bit_sel <= 3'h0;
      mode <= cob_pkg::AM_DIRECT;
      ptr_sel <= 2'h0;
      exec_go <= 1'b0;
    end else begin
      exec_go <= wr_fire && wr_off == cob_pkg::OFF_OP;
      if (wr_fire && wr_off == cob_pkg::OFF_OP) begin
        op_sel <= cob_pkg::cob_op_t'(wr_ops[cob_pkg::OP_SEL_LSB +: 4]);
        bit_sel <= wr_ops[cob_pkg::OP_BIT_LSB +: 3];
        mode <= wr_ops[cob_pkg::OP_MODE_LSB +: 3];
        ptr_sel <= wr_ops[cob_pkg::OP_PSEL_LSB +: 2];
      end
    end
  end

  assign wr_opnd = merge({8'h00, opnd_op2, opnd_imm, opnd_reg}, w_data, w_strb);
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      opnd_reg <= cob_pkg::BYTE_ZERO;
      opnd_imm <= cob_pkg::BYTE_ZERO;
      opnd_op2 <= cob_pkg::BYTE_ZERO;
    end else if (wr_fire && wr_off == cob_pkg::OFF_OPND) begin
      opnd_reg <= wr_opnd[cob_pkg::OPND_REG_LSB +: 8];
      opnd_imm <= wr_opnd[cob_pkg::OPND_IMM_LSB +: 8];
      opnd_op2 <= wr_opnd[cob_pkg::OPND_OP2_LSB +: 8];
    end
  end

  // ==================================================
  // address unit and datapath
  cob_agu_if agu_bus ();
  assign agu_bus.mode = mode;
  assign agu_bus.ptr = ptr[ptr_sel];
  assign agu_bus.imm = opnd_imm;
  assign agu_bus.regoff = offset_reg;
  cob_agu u_agu (
    .a(agu_bus)
  );

  logic mem_op;
  logic [7:0] ds_rd;
  logic [7:0] invb_val;
  logic [7:0] shl_src;
  logic [7:0] shl_val;
  logic [8:0] cmp_dif;
  assign mem_op = op_sel == cob_pkg::OP_RFLAG_MEM || op_sel == cob_pkg::OP_LOAD
               || op_sel == cob_pkg::OP_STORE;
  assign ds_rd = data_store[agu_bus.eaddr[7:0]];
  assign invb_val = opnd_reg ^ (8'h01 << bit_sel);
  assign shl_src = (op_sel == cob_pkg::OP_RFLAG_MEM) ? ds_rd : opnd_reg;
  assign shl_val = {shl_src[6:0], 1'b0};
  assign cmp_dif = {1'b0, opnd_reg} - {1'b0, opnd_op2};
  logic [1:0] wr_pidx;
  logic [31:0] wr_ptr;
  assign wr_pidx = 2'((wr_off - cob_pkg::OFF_PTR0) >> 2);
  assign wr_ptr = merge({16'h0000, ptr[wr_pidx]}, w_data, w_strb);

  // ==================================================
  // pointers, offset register and data store
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        ptr[i] <= cob_pkg::PTR_RESET;
      end
    end else if (wr_fire && wr_off >= cob_pkg::OFF_PTR0 && wr_off <= cob_pkg::OFF_PTR3) begin
      ptr[wr_pidx] <= wr_ptr[15:0];
    end else if (exec_go && mem_op && agu_bus.ptr_upd) begin
      ptr[ptr_sel] <= agu_bus.next_ptr;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      offset_reg <= cob_pkg::BYTE_ZERO;
    end else if (wr_fire && wr_off == cob_pkg::OFF_OFFREG && w_strb[0]) begin
      offset_reg <= w_data[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (wr_fire && is_ds(aw_addr) && w_strb[0]) begin
      data_store[wr_ds_idx] <= w_data[7:0];
    end else if (exec_go && op_sel == cob_pkg::OP_STORE) begin
      data_store[agu_bus.eaddr[7:0]] <= acc;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      eaddr_last <= cob_pkg::PTR_RESET;
    end else if (exec_go && mem_op) begin
      eaddr_last <= agu_bus.eaddr;
    end
  end

  // ==================================================
  // flags
  assign wr_flags = merge({29'h00000000, flag_z, flag_v, flag_c}, w_data, w_strb);
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_c <= 1'b0;
      flag_v <= 1'b0;
      flag_z <= 1'b0;
    end else if (wr_fire && wr_off == cob_pkg::OFF_FLAGS) begin
      flag_c <= wr_flags[cob_pkg::FLAG_C_BIT];
      flag_v <= wr_flags[cob_pkg::FLAG_V_BIT];
      flag_z <= wr_flags[cob_pkg::FLAG_Z_BIT];
    end else if (exec_go) begin
      case (op_sel)
        cob_pkg::OP_INVB: flag_z <= invb_val == cob_pkg::BYTE_ZERO;
        cob_pkg::OP_RFLAG_REG, cob_pkg::OP_RFLAG_MEM: begin
          flag_c <= shl_src[7];
          flag_v <= 1'b0;
          flag_z <= shl_val == cob_pkg::BYTE_ZERO;
        end
        cob_pkg::OP_CMP: begin
          flag_c <= ~cmp_dif[8];
          flag_v <= (opnd_reg[7] ^ opnd_op2[7]) & (opnd_reg[7] ^ cmp_dif[7]);
          flag_z <= cmp_dif[7:0] == cob_pkg::BYTE_ZERO;
        end
        default: flag_z <= flag_z;
      endcase
    end
  end

  // ==================================================
  // accumulator and result
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      acc <= cob_pkg::BYTE_ZERO;
      result <= cob_pkg::BYTE_ZERO;
    end else if (exec_go) begin
      case (op_sel)
        cob_pkg::OP_INVB: begin
          acc <= invb_val;
          result <= invb_val;
        end
        cob_pkg::OP_SFLAG: acc <= {flag_c, flag_c ^ flag_v, CALL_PILE_FULL,
                                   CALL_PILE_EMPTY, cob_pkg::SNAP_LOW};
        cob_pkg::OP_RFLAG_REG, cob_pkg::OP_RFLAG_MEM: acc <= shl_val;
        cob_pkg::OP_LOAD: acc <= ds_rd;
        default: acc <= acc;
      endcase
    end
  end

  // ==================================================
  // clock ratio
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cpu_div <= cob_pkg::DIV_NONE;
    end else if (exec_go && op_sel == cob_pkg::OP_FREQ && bit_sel <= cob_pkg::DIV_16) begin
      cpu_div <= cob_pkg::cob_div_t'(bit_sel);
    end
  end

  // ==================================================
  // jump condition
  logic cond_now;
  cob_cond u_cond (
    .code(cond_code),
    .flag_c(flag_c),
    .flag_v(flag_v),
    .flag_z(flag_z),
    .ev0(EVENT_LINE_ZERO),
    .ev1(EVENT_LINE_ONE),
    .taken(cond_now)
  );

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cond_code <= 4'h0;
      jump_taken <= 1'b0;
    end else begin
      jump_taken <= cond_now;
      if (wr_fire && wr_off == cob_pkg::OFF_COND && w_strb[0]) begin
        cond_code <= w_data[3:0];
      end
    end
  end
endmodule : cob_top

// ==== tb/cob_top_asserts.sv ====
// bus and output checker for the operand and branch block
`timescale 1ns/1ps
module cob_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // bus
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // outputs
  input wire logic [2:0] CPU_CLK_DIV,
  input wire logic JUMP_TAKEN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("ar open");
  write_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("aw or w open");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read late");
  bresp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP inside {2'h0, 2'h2})
    else $error("bad bresp");
  div_range_a: assert property (CPU_CLK_DIV <= 3'h4) else $error("bad divide");
  div_cause_a: assert property ($changed(CPU_CLK_DIV) |-> S_AXI_BVALID ||
    $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2)) else $error("divide without op");
  slverr_c: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
  div16_c: cover property (CPU_CLK_DIV == 3'h4);
  jump_c: cover property ($rose(JUMP_TAKEN));
endmodule : cob_chk
bind cob_top cob_chk chk (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .CPU_CLK_DIV(CPU_CLK_DIV), .JUMP_TAKEN(JUMP_TAKEN));

// ==== tb/testbench.sv ====
// self-checking bench for the operand and branch block
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, awv, wv, bre, arv, rre, full, emp, e0, e1, awr, wrd, bv, arr, rv, jt;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd_data, rdv, r, b, e, f, v, im, of, pv, ea;
  logic [1:0] br, rr, resp, ps;
  logic [2:0] div, md;
  int bad_count, comparisons;
  cob_top uut (.MCLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_data),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .CALL_PILE_FULL(full),
    .CALL_PILE_EMPTY(emp), .EVENT_LINE_ZERO(e0), .EVENT_LINE_ONE(e1), .CPU_CLK_DIV(div),
    .JUMP_TAKEN(jt));
  // ==================================================
  // clock and bus tasks
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
    end while (awv || wv || !bv);
    resp = br;
    bre <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end while (arv || !rv);
    rdv = rd_data;
    resp = rr;
    rre <= 0;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ==================================================
  // expectations
  function automatic logic [11:0] da(input logic [7:0] x);
    return cob_pkg::OFF_DS_BASE + {2'h0, x, 2'h0};
  endfunction : da
  function automatic logic [31:0] agu(input logic [2:0] m, input logic [15:0] p,
                                      input logic [7:0] i, input logic [7:0] o);
    logic [15:0] a;
    case (m)
      3'h2, 3'h5: a = p + {8'h00, i};
      3'h3: a = p + {8'h00, o};
      3'h6: a = p - 16'h0001;
      3'h7: a = p - {8'h00, i};
      default: a = p;
    endcase
    return {(m == 3'h4) ? p + 16'h0001 : (m > 3'h4) ? a : p, a};
  endfunction : agu
  function automatic logic [31:0] cexp(input int k, input logic [2:0] fl, input logic ev);
    case (k)
      0, 10: return {31'h0, fl[0]};
      1, 11: return {31'h0, !fl[0]};
      2, 7: return {31'h0, fl[2]};
      3, 8: return {31'h0, !fl[2]};
      4: return {31'h0, fl[1]};
      5: return {31'h0, !fl[1]};
      6: return {31'h0, ev};
      9: return {31'h0, fl[0] & !fl[2]};
      12: return {31'h0, !fl[0] | fl[2]};
      default: return 32'h0;
    endcase
  endfunction : cexp
  // ==================================================
  // watchdog
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  // ==================================================
  // main sequence
  initial begin
    {awv, wv, bre, arv, rre, full, emp, e0, e1} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    rst_n = 0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'hB61DEB4E));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd(12'h030);
    chk(rdv | {30'h0, resp}, 32'h2);
    wr(12'h030, 32'h0);
    chk({30'h0, resp}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      r = $urandom & 32'hFF;
      b = $urandom % 8;
      f = $urandom % 4;
      v = $urandom;
      full <= v[0];
      emp <= v[1];
      e0 <= v[2];
      e1 <= v[3];
      wr(cob_pkg::OFF_FLAGS, f);
      wr(cob_pkg::OFF_OPND, r);
      wr(cob_pkg::OFF_OP, b << 4);
      e = r ^ (32'h1 << b);
      rd(cob_pkg::OFF_RESULT);
      chk(rdv & 32'hFF, e);
      rd(cob_pkg::OFF_ACC);
      chk(rdv & 32'hFF, e);
      rd(cob_pkg::OFF_FLAGS);
      chk(rdv & 32'h7, {29'h0, e == 0, f[1:0]});
      wr(cob_pkg::OFF_FLAGS, f);
      wr(cob_pkg::OFF_OP, 32'h1);
      rd(cob_pkg::OFF_ACC);
      chk(rdv & 32'hFF, {24'h0, f[0], f[0] ^ f[1], v[0], v[1], 4'h0});
      rd(cob_pkg::OFF_FLAGS);
      chk(rdv & 32'h7, f);
      wr(cob_pkg::OFF_OP, 32'h2);
      e = (r << 1) & 32'hFE;
      rd(cob_pkg::OFF_ACC);
      chk(rdv & 32'hFF, e);
      rd(cob_pkg::OFF_FLAGS);
      chk(rdv & 32'h7, {29'h0, e == 0, 1'h0, r[7]});
      im = $urandom & 32'hFF;
      wr(da(im[7:0]), r ^ 32'h80);
      wr(cob_pkg::OFF_OPND, im << 8);
      wr(cob_pkg::OFF_OP, 32'h3);
      rd(cob_pkg::OFF_ACC);
      chk(rdv & 32'hFF, ((r ^ 32'h80) << 1) & 32'hFE);
      rd(cob_pkg::OFF_FLAGS);
      chk(rdv & 32'h1, {31'h0, !r[7]});
      wr(cob_pkg::OFF_OP, 32'h7);
      rd(da(im[7:0]));
      chk(rdv, ((r ^ 32'h80) << 1) & 32'hFE);
      wr(cob_pkg::OFF_FLAGS, f ^ 32'h4);
      wr(cob_pkg::OFF_OP, 32'h4 | ((i % 5) << 4));
      rd(cob_pkg::OFF_FLAGS);
      chk(rdv & 32'h707, ((i % 5) << 8) | (f ^ 32'h4));
      chk({29'h0, div}, i % 5);
      md = 3'(i % 7 + 1);
      ps = 2'($urandom);
      pv = $urandom & 32'hFFFF;
      of = $urandom & 32'hFF;
      ea = agu(md, pv[15:0], im[7:0], of[7:0]);
      wr(cob_pkg::OFF_PTR0 + {ps, 2'h0}, pv);
      wr(cob_pkg::OFF_OFFREG, of);
      wr(da(ea[7:0]), r);
      wr(cob_pkg::OFF_OP, {18'h0, ps, 1'h0, md, 8'h06});
      rd(cob_pkg::OFF_ACC);
      chk(rdv & 32'hFF, r);
      rd(cob_pkg::OFF_EADDR);
      chk(rdv & 32'hFFFF, ea & 32'hFFFF);
      rd(cob_pkg::OFF_PTR0 + {ps, 2'h0});
      chk(rdv & 32'hFFFF, ea >> 16);
      b = (i % 3 == 0) ? r : ($urandom & 32'hFF);
      wr(cob_pkg::OFF_OPND, r | (b << 16));
      wr(cob_pkg::OFF_OP, 32'h5);
      e = r - b;
      f = {29'h0, r == b, (r[7] != b[7]) && (e[7] != r[7]), r >= b};
      for (int k = 0; k < 14; k++) begin
        wr(cob_pkg::OFF_COND, k);
        rd(cob_pkg::OFF_COND);
        chk(rdv & 32'h10, cexp(k, f[2:0], v[2] | v[3]) << 4);
        chk({31'h0, jt}, cexp(k, f[2:0], v[2] | v[3]));
      end
    end
    final_report();
  end
endmodule : testbench
